// [serdes_pkg.sv]
// Shared constants, types and config decoders for the serial link ends.
// Assumes one serial bit per core_clk cycle on the modelled link.
package serdes_pkg;
   localparam int W_MAX            = 20;
   localparam int FIFO_DEPTH       = 4;
   localparam int CENTER_CH_A      = 4;
   localparam int CENTER_CH_B      = 5;
   localparam int CORE_CLK_MHZ     = 250;
   localparam int BITS_PER_CLK     = 1;
   localparam int LINK_MBPS        = CORE_CLK_MHZ * BITS_PER_CLK;
   localparam int SS_MAX_MBPS      = 840;
   localparam int CDR_MAX_MBPS     = 1250;
   localparam int RAPIDIO_MAX_MBPS = 500;

   typedef enum logic {
      MODE_SSYNC = 1'b0,
      MODE_CDR   = 1'b1
   } link_mode_t;

   // Gray path: idle -> align -> run
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_ALIGN = 2'b01,
      RX_RUN   = 2'b11
   } rx_state_t;

   function automatic logic legal_mult(input logic [4:0] v);
      return (v >= 5'h01 && v <= 5'h0c) || v == 5'h0e || v == 5'h10 || v == 5'h12 || v == 5'h14;
   endfunction

   function automatic logic legal_width(input link_mode_t m, input logic [4:0] v);
      logic base;
      base = (v >= 5'h08 && v <= 5'h0c) || v == 5'h0e || v == 5'h10 || v == 5'h12 || v == 5'h14;
      if (m == MODE_SSYNC)
         return base || v == 5'h04 || v == 5'h07;
      return base || (v >= 5'h03 && v <= 5'h07);
   endfunction
endpackage

// [serdes_link_if.sv]
// Serial lanes between the device end and the remote end.
// dn_* runs remote to device, up_* device to remote; each with forwarded clock.
`timescale 1ns/1ps
interface serdes_link_if;
   logic dn_data;
   logic dn_fclk;
   logic up_data;
   logic up_fclk;
   modport device (input dn_data, input dn_fclk, output up_data, output up_fclk);
   modport remote (output dn_data, output dn_fclk, input up_data, input up_fclk);
endinterface

// [serdes_fifo.sv]
// Word synchroniser FIFO, valid/ready on both sides.
// Assumes DEPTH a power of two; both sides on core_clk.
`timescale 1ns/1ps
module serdes_fifo
   import serdes_pkg::*;
#(
   parameter int WIDTH = W_MAX,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_cfg
      $error("serdes_fifo: DEPTH must be a power of two >= 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wp;
      logic [AW:0]                 rp;
   } fifo_state_t;

   fifo_state_t s;
   fifo_state_t next_s;
   logic        full;
   logic        empty;

   assign full      = (s.wp[AW] != s.rp[AW]) && (s.wp[AW-1:0] == s.rp[AW-1:0]);
   assign empty     = s.wp == s.rp;
   assign in_ready  = ~full;
   assign out_valid = ~empty;
   assign out_data  = s.mem[s.rp[AW-1:0]];

   always_comb begin
      next_s = s;
      if (in_valid && !full) begin
         next_s.mem[s.wp[AW-1:0]] = in_data;
         next_s.wp                = s.wp + 1'b1;
      end
      if (out_ready && !empty)
         next_s.rp = s.rp + 1'b1;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end
endmodule

// [serdes_device_end.sv]
// Device end: one receive and one transmit serial channel with word FIFO.
// Assumes config stays stable while enable is high; link pins are async.
// Operation
// - Receiver checks forwarded clock multiply factor.
// - Source-synchronous word width from legal set.
// - Data lane travels with forwarded clock.
// - Recovery mode multiplies reference to line rate.
// - Recovered clock drives deserializer and synchronizer.
// - FIFO moves words into core domain.
// - FIFO bypass delivers words directly.
// - Recovery mode width from legal set.
// - Recovered clock divided by width exported.
// - Transmitter serializes on multiplied reference.
// - At most two rates per direction.
// - Remote sends non-return-to-zero data.
// - Core aligns words after recovery.
// - Run length waived for shared source.
// - Only center channels drive global clock.
// - Reference clock reaches only the multipliers.
// - Source-synchronous mode carries RapidIO rates.
`timescale 1ns/1ps
module serdes_device_end
   import serdes_pkg::*;
#(
   parameter int WIDTH   = W_MAX,
   parameter int DEPTH   = FIFO_DEPTH,
   parameter int CHANNEL = CENTER_CH_A
)(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   serdes_link_if.device         link,
   input  wire logic             enable,
   input  wire link_mode_t       mode,
   input  wire logic [4:0]       rx_width,
   input  wire logic [4:0]       rx_mult,
   input  wire logic [4:0]       tx_width,
   input  wire logic [4:0]       tx_mult,
   input  wire logic             fifo_bypass,
   output logic      [WIDTH-1:0] rx_word,
   output logic                  rx_valid,
   input  wire logic             rx_ready,
   output logic                  rx_word_tick,
   output logic                  rx_global_clk,
   output logic                  rx_lock,
   output logic                  rx_overflow,
   output logic                  cfg_err,
   input  wire logic [WIDTH-1:0] tx_word,
   input  wire logic             tx_valid,
   output logic                  tx_ready
);
   localparam logic IS_CENTER = (CHANNEL == CENTER_CH_A) || (CHANNEL == CENTER_CH_B);

   // Modelled line rate must sit under each mode's ceiling
   if (WIDTH != W_MAX || LINK_MBPS > SS_MAX_MBPS || LINK_MBPS > CDR_MAX_MBPS) begin : g_bad_cfg
      $error("serdes_device_end: unsupported width or line rate");
   end

   typedef struct packed {
      logic [1:0]       dsync;
      logic [1:0]       fsync;
      logic             fprev;
      rx_state_t        st;
      logic [WIDTH-1:0] sh;
      logic [4:0]       bcnt;
      logic [4:0]       pcnt;
      logic             lock;
      logic [WIDTH-1:0] word;
      logic             wstb;
      logic             ovf;
      logic             cerr;
      logic             ton;
      logic [WIDTH-1:0] tsh;
      logic [4:0]       tcnt;
      logic [4:0]       fcnt;
      logic             tdat;
      logic             tfclk;
   } dev_state_t;

   dev_state_t       s;
   dev_state_t       next_s;
   logic             cfg_ok;
   logic             run_ok;
   logic             rise;
   logic             take;
   logic [WIDTH-1:0] cur;
   logic [4:0]       half;
   logic             f_in_ready;
   logic             f_out_valid;
   logic [WIDTH-1:0] f_out_data;

   // Single channel per direction, so the two-rate budget always holds
   assign cfg_ok = legal_mult(rx_mult) && legal_mult(tx_mult)
                && legal_width(mode, rx_width) && legal_width(mode, tx_width);
   assign run_ok = enable && cfg_ok;
   assign half   = 5'((6'(tx_mult) + 6'h01) >> 1);

   always_comb begin
      next_s       = s;
      rise         = s.fsync[1] && !s.fprev;
      take         = 1'b0;
      cur          = '0;
      // Two flops before any logic looks at the pins
      next_s.dsync = {s.dsync[0], link.dn_data};
      next_s.fsync = {s.fsync[0], link.dn_fclk};
      next_s.fprev = s.fsync[1];
      next_s.wstb  = 1'b0;
      next_s.cerr  = !cfg_ok;
      next_s.ton   = run_ok;

      if (!run_ok) begin
         next_s.st   = RX_IDLE;
         next_s.sh   = '0;
         next_s.bcnt = 5'h00;
         next_s.pcnt = 5'h00;
         next_s.lock = 1'b0;
         next_s.ovf  = 1'b0;
      end else begin
         case (s.st)
            RX_IDLE:  next_s.st = (mode == MODE_CDR) ? RX_RUN : RX_ALIGN;
            RX_ALIGN: begin
               if (rise)
                  next_s.st = RX_RUN; // Word boundary at forwarded clock edge
            end
            RX_RUN:   next_s.st = RX_RUN;
            default:  next_s.st = RX_IDLE;
         endcase
         // Recovered bit clock: one bit per core_clk in both modes
         // In recovery mode the boundary is arbitrary; core realigns
         take = (s.st == RX_RUN) || (s.st == RX_ALIGN && rise);
         if (take) begin
            next_s.sh[s.bcnt] = s.dsync[1];
            if (s.bcnt == rx_width - 5'h01) begin
               next_s.word = next_s.sh;
               next_s.wstb = 1'b1;
               next_s.sh   = '0;
               next_s.bcnt = 5'h00;
            end else begin
               next_s.bcnt = s.bcnt + 5'h01;
            end
         end
         if (mode == MODE_SSYNC) begin
            // Lock means the forwarded period equals the multiply factor
            if (rx_mult == 5'h01) begin
               next_s.lock = s.fsync[1] && s.st != RX_IDLE;
            end else if (rise) begin
               next_s.lock = s.pcnt == rx_mult - 5'h01;
               next_s.pcnt = 5'h00;
            end else begin
               if (s.pcnt != 5'h1f)
                  next_s.pcnt = s.pcnt + 5'h01;
               if (s.pcnt >= rx_mult)
                  next_s.lock = 1'b0;
            end
         end else begin
            next_s.lock = s.st == RX_RUN;
         end
      end
      // Sticky until disable, set beats clear; outside bypass a full FIFO is the only way a word is lost
      if (s.wstb && !fifo_bypass && !f_in_ready)
         next_s.ovf = 1'b1;

      // Transmitter runs free once enabled, idle words are zero
      if (run_ok && s.ton) begin
         cur          = (s.tcnt == 5'h00) ? (tx_valid ? tx_word : '0) : s.tsh;
         next_s.tsh   = cur;
         next_s.tdat  = cur[s.tcnt];
         next_s.tcnt  = (s.tcnt == tx_width - 5'h01) ? 5'h00 : s.tcnt + 5'h01;
         next_s.fcnt  = (s.fcnt == tx_mult - 5'h01) ? 5'h00 : s.fcnt + 5'h01;
         next_s.tfclk = (mode == MODE_SSYNC) && (s.fcnt < half);
      end else begin
         next_s.tcnt  = 5'h00;
         next_s.fcnt  = 5'h00;
         next_s.tdat  = 1'b0;
         next_s.tfclk = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   serdes_fifo #(
      .WIDTH (WIDTH),
      .DEPTH (DEPTH)
   ) u_sync_fifo (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .in_valid  (s.wstb && !fifo_bypass),
      .in_ready  (f_in_ready),
      .in_data   (s.word),
      .out_valid (f_out_valid),
      .out_ready (rx_ready && !fifo_bypass),
      .out_data  (f_out_data)
   );

   // Bypass gives no back-pressure: a word stands one cycle only
   assign rx_valid      = fifo_bypass ? s.wstb : f_out_valid;
   assign rx_word       = fifo_bypass ? s.word : f_out_data;
   assign rx_word_tick  = s.wstb;
   assign rx_global_clk = IS_CENTER && s.wstb;
   assign rx_lock       = s.lock;
   assign rx_overflow   = s.ovf;
   assign cfg_err       = s.cerr;
   assign tx_ready      = run_ok && s.ton && s.tcnt == 5'h00;
   // No reference clock pin feeds core logic; core_clk stands for it
   assign link.up_data  = s.tdat;
   assign link.up_fclk  = s.tfclk;
endmodule

// [serdes_remote_end.sv]
// Remote end: serial transmitter and simple receiver facing the device.
// Assumes config stays stable while enable is high; link pins are async.
`timescale 1ns/1ps
module serdes_remote_end
   import serdes_pkg::*;
#(
   parameter int WIDTH = W_MAX
)(
   input  wire logic             core_clk,
   input  wire logic             rst_n,
   serdes_link_if.remote         link,
   input  wire logic             enable,
   input  wire link_mode_t       mode,
   input  wire logic [4:0]       tx_width,
   input  wire logic [4:0]       tx_mult,
   input  wire logic [4:0]       rx_width,
   input  wire logic [WIDTH-1:0] tx_word,
   input  wire logic             tx_valid,
   output logic                  tx_ready,
   output logic      [WIDTH-1:0] rx_word,
   output logic                  rx_valid
);
   if (WIDTH != W_MAX) begin : g_bad_cfg
      $error("serdes_remote_end: WIDTH must equal W_MAX");
   end

   typedef struct packed {
      logic [1:0]       dsync;
      logic [1:0]       fsync;
      logic             fprev;
      rx_state_t        st;
      logic [WIDTH-1:0] sh;
      logic [4:0]       bcnt;
      logic [WIDTH-1:0] word;
      logic             wstb;
      logic             ton;
      logic [WIDTH-1:0] tsh;
      logic [4:0]       tcnt;
      logic [4:0]       fcnt;
      logic             tdat;
      logic             tfclk;
   } rem_state_t;

   rem_state_t       s;
   rem_state_t       next_s;
   logic             run_ok;
   logic             take;
   logic [WIDTH-1:0] cur;
   logic [4:0]       half;

   assign run_ok = enable && legal_mult(tx_mult) && legal_width(mode, tx_width) && legal_width(mode, rx_width);
   assign half   = 5'((6'(tx_mult) + 6'h01) >> 1);

   always_comb begin
      next_s       = s;
      take         = 1'b0;
      cur          = '0;
      next_s.dsync = {s.dsync[0], link.up_data};
      next_s.fsync = {s.fsync[0], link.up_fclk};
      next_s.fprev = s.fsync[1];
      next_s.wstb  = 1'b0;
      next_s.ton   = run_ok;
      if (!run_ok) begin
         next_s.st   = RX_IDLE;
         next_s.sh   = '0;
         next_s.bcnt = 5'h00;
      end else begin
         case (s.st)
            RX_IDLE:  next_s.st = (mode == MODE_CDR) ? RX_RUN : RX_ALIGN;
            RX_ALIGN: begin
               if (s.fsync[1] && !s.fprev)
                  next_s.st = RX_RUN;
            end
            RX_RUN:   next_s.st = RX_RUN;
            default:  next_s.st = RX_IDLE;
         endcase
         take = (s.st == RX_RUN) || (s.st == RX_ALIGN && s.fsync[1] && !s.fprev);
         if (take) begin
            next_s.sh[s.bcnt] = s.dsync[1];
            if (s.bcnt == rx_width - 5'h01) begin
               next_s.word = next_s.sh;
               next_s.wstb = 1'b1;
               next_s.sh   = '0;
               next_s.bcnt = 5'h00;
            end else begin
               next_s.bcnt = s.bcnt + 5'h01;
            end
         end
      end
      // Plain NRZ, one bit per cycle, LSB first
      if (run_ok && s.ton) begin
         cur          = (s.tcnt == 5'h00) ? (tx_valid ? tx_word : '0) : s.tsh;
         next_s.tsh   = cur;
         next_s.tdat  = cur[s.tcnt];
         next_s.tcnt  = (s.tcnt == tx_width - 5'h01) ? 5'h00 : s.tcnt + 5'h01;
         next_s.fcnt  = (s.fcnt == tx_mult - 5'h01) ? 5'h00 : s.fcnt + 5'h01;
         next_s.tfclk = (mode == MODE_SSYNC) && (s.fcnt < half);
      end else begin
         next_s.tcnt  = 5'h00;
         next_s.fcnt  = 5'h00;
         next_s.tdat  = 1'b0;
         next_s.tfclk = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n)
         s <= '0;
      else
         s <= next_s;
   end

   assign tx_ready     = run_ok && s.ton && s.tcnt == 5'h00;
   assign rx_word      = s.word;
   assign rx_valid     = s.wstb;
   assign link.dn_data = s.tdat;
   assign link.dn_fclk = s.tfclk;
endmodule

// [serdes_link_sva.sv]
// Checker for the device end of the serial link pair.
// Assumes instantiation beside the link interface, one core_clk domain.
`timescale 1ns/1ps
module serdes_link_sva
   import serdes_pkg::*;
#(
   parameter int WIDTH   = W_MAX,
   parameter int CHANNEL = CENTER_CH_A
)(
   input wire logic             core_clk,
   input wire logic             rst_n,
   input wire logic             up_data,
   input wire logic             up_fclk,
   input wire logic             enable,
   input wire link_mode_t       mode,
   input wire logic             fifo_bypass,
   input wire logic [4:0]       rx_width,
   input wire logic [WIDTH-1:0] tx_word,
   input wire logic             tx_valid,
   input wire logic             tx_ready,
   input wire logic             rx_word_tick,
   input wire logic             rx_global_clk,
   input wire logic             rx_valid,
   input wire logic             rx_overflow,
   input wire logic             cfg_err
);
   logic [5:0] gap;
   logic       seen;
   // Spacing is only judged after one tick, so restarts never count
   always_ff @(posedge core_clk) begin
      if (!rst_n || !enable) begin
         gap  <= 6'h00;
         seen <= 1'b0;
      end else if (rx_word_tick) begin
         gap  <= 6'h01;
         seen <= 1'b1;
      end else begin
         gap <= gap + 6'h01;
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_tick_period: assert property (rx_word_tick && seen |-> gap == {1'b0, rx_width})
      else $error("word tick spacing differs from width");
   a_global_gate: assert property (rx_global_clk == ((CHANNEL == CENTER_CH_A || CHANNEL == CENTER_CH_B) && rx_word_tick))
      else $error("global clock output wrong");
   a_cdr_fclk_low: assert property (mode == MODE_CDR && $past(mode, 2) == MODE_CDR |-> !up_fclk)
      else $error("forwarded clock toggles in recovery mode");
   a_tx_first_bit: assert property (tx_ready && tx_valid |=> up_data == $past(tx_word[0]))
      else $error("first serial bit wrong");
   a_tx_third_bit: assert property (tx_ready && tx_valid ##1 enable [*3] |-> up_data == $past(tx_word[2], 3))
      else $error("third serial bit wrong");
   a_tx_ready_gap: assert property (tx_ready |=> !tx_ready [*2])
      else $error("transmit ready too often");
   a_cfg_blocks_tx: assert property (cfg_err |-> !tx_ready)
      else $error("transmit ready with bad config");
   a_overflow_hold: assert property (rx_overflow && enable |=> rx_overflow)
      else $error("overflow cleared while enabled");
   a_bypass_pulse: assert property (fifo_bypass && $past(fifo_bypass) |-> rx_valid == rx_word_tick)
      else $error("bypass valid not with tick");
   a_bypass_single: assert property (fifo_bypass && rx_valid ##1 fifo_bypass |-> !rx_valid)
      else $error("bypass word stood longer than one cycle");
   a_fifo_write: assert property (!fifo_bypass && enable && rx_word_tick |=> rx_valid)
      else $error("word not visible after write");
endmodule

// [diff_serdes_cdr_channels_tb_top.sv]
// Bench top: device end and remote end joined over the link interface.
// Assumes a 250 MHz core clock shared by both ends.
`timescale 1ns/1ps
module diff_serdes_cdr_channels_tb_top;
   import serdes_pkg::*;
   logic        core_clk   = 1'b0;
   logic        rst_n      = 1'b0;
   logic        enable     = 1'b0;
   link_mode_t  mode       = MODE_SSYNC;
   logic [4:0]  w          = 5'h08;
   logic [4:0]  m          = 5'h08;
   logic [4:0]  tm         = 5'h08;
   logic        byp        = 1'b0;
   logic        txv        = 1'b1;
   logic        stall      = 1'b0;
   logic        d_rx_ready = 1'b1;
   logic [19:0] d_tx_word  = 20'h00000;
   logic [19:0] r_tx_word  = 20'h00000;
   logic [19:0] d_rx_word, r_rx_word;
   logic        d_rx_valid, r_rx_valid, d_tx_ready, r_tx_ready, tick, gclk, lock, ovf, cerr;
   int          errors = 0, checked = 0, di = 0, ri = 0, dn = 0, rn = 0, nchk = 0, nt, ng;
   logic [4:0]  cw [4] = '{5'h08, 5'h14, 5'h04, 5'h07};
   logic [4:0]  cm [4] = '{5'h04, 5'h14, 5'h01, 5'h0e};
   logic        cb [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
   serdes_link_if link ();
   // Both ends share core_clk and one rate, so no run-length limit applies
   always #2 core_clk = ~core_clk;
   serdes_device_end #(.WIDTH(20), .DEPTH(4), .CHANNEL(CENTER_CH_A)) i_serdes_device_end (
      .core_clk(core_clk), .rst_n(rst_n), .link(link), .enable(enable), .mode(mode),
      .rx_width(w), .rx_mult(m), .tx_width(w), .tx_mult(tm), .fifo_bypass(byp),
      .rx_word(d_rx_word), .rx_valid(d_rx_valid), .rx_ready(d_rx_ready), .rx_word_tick(tick),
      .rx_global_clk(gclk), .rx_lock(lock), .rx_overflow(ovf), .cfg_err(cerr),
      .tx_word(d_tx_word), .tx_valid(txv), .tx_ready(d_tx_ready));
   serdes_remote_end #(.WIDTH(20)) i_serdes_remote_end (
      .core_clk(core_clk), .rst_n(rst_n), .link(link), .enable(enable), .mode(mode),
      .tx_width(w), .tx_mult(m), .rx_width(w), .tx_word(r_tx_word), .tx_valid(txv),
      .tx_ready(r_tx_ready), .rx_word(r_rx_word), .rx_valid(r_rx_valid));
   serdes_link_sva #(.WIDTH(20), .CHANNEL(CENTER_CH_A)) i_serdes_link_sva (
      .core_clk(core_clk), .rst_n(rst_n), .up_data(link.up_data), .up_fclk(link.up_fclk),
      .enable(enable), .mode(mode), .fifo_bypass(byp), .rx_width(w), .tx_word(d_tx_word),
      .tx_valid(txv), .tx_ready(d_tx_ready), .rx_word_tick(tick), .rx_global_clk(gclk),
      .rx_valid(d_rx_valid), .rx_overflow(ovf), .cfg_err(cerr));

   function automatic logic [19:0] pat(input int k, input logic s);
      logic [19:0] v;
      v = 20'h9c4e1 ^ (20'(k) * 20'h3b5a7) ^ {20{s}};
      return v & ((20'h00001 << w) - 20'h00001);
   endfunction

   function automatic logic ok(input int v, input int kind);
      if (v inside {14, 16, 18, 20})
         return 1'b1;
      if (kind == 0)
         return v >= 1 && v <= 12;
      if (kind == 1)
         return v == 4 || (v >= 7 && v <= 12);
      return v >= 3 && v <= 12;
   endfunction

   task automatic cmp(input string what, input logic [19:0] exp, input logic [19:0] got);
      checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cmp_cnt(input string what, input int exp, input int got);
      checked++;
      if (got != exp) begin
         errors++;
         $display("ERROR %s expected %0d seen %0d", what, exp, got);
      end
   endtask

   // Config only moves while disabled; long gap lets the FIFO drain
   task automatic set_cfg(input link_mode_t md, input logic [4:0] wv, mv, tv, input logic bp, input int n);
      @(negedge core_clk);
      enable = 1'b0;
      repeat (8) @(negedge core_clk);
      mode = md;
      w = wv;
      m = mv;
      tm = tv;
      byp = bp;
      nchk = n;
      ri = 0;
      di = 0;
      dn = 0;
      rn = 0;
      @(negedge core_clk);
      enable = 1'b1;
   endtask

   task automatic chk_cfg(input link_mode_t md, input logic [4:0] wv, mv, tv, input logic e);
      set_cfg(md, wv, mv, tv, 1'b0, 0);
      repeat (3) @(negedge core_clk);
      cmp("cfg_err", 20'(e), 20'(cerr));
   endtask

   task automatic wait_words();
      for (int t = 0; t < 2000 && (dn < nchk || rn < nchk); t++)
         @(negedge core_clk);
      cmp_cnt("device words", nchk, dn);
      cmp_cnt("remote words", nchk, rn);
   endtask

   task automatic report_and_stop();
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   always @(posedge core_clk) begin
      if (txv && r_tx_ready)
         ri <= ri + 1;
      if (txv && d_tx_ready)
         di <= di + 1;
   end

   // Both streams send an endless known sequence, so words must arrive in order
   // Ready is set before the check, so a counted pop is the one the FIFO takes next edge
   always @(negedge core_clk) begin
      d_rx_ready = !stall;
      r_tx_word <= pat(ri, 1'b0);
      d_tx_word <= pat(di, 1'b1);
      if (d_rx_valid === 1'b1 && (d_rx_ready || byp) && dn < nchk) begin
         cmp("device rx word", pat(dn, 1'b0), d_rx_word);
         dn++;
      end
      if (r_rx_valid === 1'b1 && rn < nchk) begin
         cmp("remote rx word", pat(rn, 1'b1), r_rx_word);
         rn++;
      end
   end

   initial begin
      #(4 * 20000);
      errors++;
      $display("ERROR watchdog expected finish seen hang");
      report_and_stop();
   end

   initial begin
      repeat (16) @(negedge core_clk);
      rst_n = 1'b1;
      for (int v = 0; v < 32; v++) begin
         chk_cfg(MODE_SSYNC, 5'(v), 5'h08, 5'h08, !ok(v, 1));
         chk_cfg(MODE_CDR, 5'(v), 5'h08, 5'h08, !ok(v, 2));
         chk_cfg(MODE_SSYNC, 5'h08, 5'(v), 5'h08, !ok(v, 0));
         chk_cfg(MODE_SSYNC, 5'h08, 5'h08, 5'(v), !ok(v, 0));
      end
      $display("config sweep done");
      for (int i = 0; i < 4; i++) begin
         set_cfg(MODE_SSYNC, cw[i], cm[i], cm[i], cb[i], 12);
         wait_words();
         cmp("rx_lock", 20'h00001, 20'(lock));
         $display("word test %0d done", i);
      end
      stall = 1'b1;
      set_cfg(MODE_SSYNC, 5'h08, 5'h08, 5'h08, 1'b0, 4);
      for (int t = 0; t < 300 && ovf !== 1'b1; t++)
         @(negedge core_clk);
      cmp("rx_overflow", 20'h00001, 20'(ovf));
      cmp("rx_valid full", 20'h00001, 20'(d_rx_valid));
      stall = 1'b0;
      wait_words();
      cmp("rx_overflow kept", 20'h00001, 20'(ovf));
      $display("overflow test done");
      // Recovered words are not compared: alignment is left to the core
      set_cfg(MODE_CDR, 5'h03, 5'h0a, 5'h0a, 1'b0, 0);
      repeat (100) @(negedge core_clk);
      for (int t = 0; t < 50 && tick !== 1'b1; t++)
         @(negedge core_clk);
      nt = 0;
      ng = 0;
      repeat (30) begin
         @(negedge core_clk);
         nt += int'(tick === 1'b1);
         ng += int'(gclk === 1'b1);
      end
      cmp_cnt("word ticks", 10, nt);
      cmp_cnt("global clocks", 10, ng);
      cmp("rx_lock cdr", 20'h00001, 20'(lock));
      cmp("dn_fclk cdr", 20'h00000, 20'(link.dn_fclk));
      $display("recovery test done");
      report_and_stop();
   end
endmodule
